// >>> sam_cpu_model.sv
/*
  Processor model that issues security register and memory accesses.
  Assumes mclk comes from the bench; each task issues one request.
*/
`timescale 1ns/1ps
module sam_cpu_model
  import sam_pkg::*;
(
  // Clock.
  input  wire logic          mclk,
  // Security register strobes.
  output logic               sec_wr    = 1'h0,
  output logic               sec_rd    = 1'h0,
  output logic               sec_priv  = 1'h0,
  output logic [3:0]         sec_idx   = 4'h0,
  output logic [DW-1:0]      sec_wdata = 32'h0000_0000,
  // Memory access under check.
  output logic               acc_valid = 1'h0,
  output logic [AW-1:0]      acc_addr  = 16'h0000,
  output logic               acc_write = 1'h0,
  output logic               acc_fetch = 1'h0,
  output logic               acc_user  = 1'h0
);
  // ----------------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------------
  // Issues one register read or write; released data lines are inverted.
  task automatic reg_op(input logic w, input logic p, input logic [3:0] i,
                        input logic [DW-1:0] d);
    @(posedge mclk);
    sec_wr    <= w;
    sec_rd    <= ~w;
    sec_priv  <= p;
    sec_idx   <= i;
    sec_wdata <= d;
    @(posedge mclk);
    sec_wr    <= 1'h0;
    sec_rd    <= 1'h0;
    sec_wdata <= ~d;
  endtask : reg_op

  // Issues one memory access lasting a single cycle.
  task automatic acc_op(input logic [AW-1:0] a, input logic w, input logic f,
                        input logic u);
    @(posedge mclk);
    acc_valid <= 1'h1;
    acc_addr  <= a;
    acc_write <= w;
    acc_fetch <= f;
    acc_user  <= u;
    @(posedge mclk);
    acc_valid <= 1'h0;
    acc_addr  <= ~a;
  endtask : acc_op
endmodule : sam_cpu_model

// >>> sam_monitor.sv
/*
  Security access monitor: detector capture and reaction, pin filters,
  security register file with write-enable window, memory access checks,
  fast interrupt causes, test/normal life cycle and key control.
  Assumes accesses and register strobes come from logic on mclk; detector,
  strap and external reset/clock pins are asynchronous.
*/
// Behaviour
// - Every detector event is latched in a readable status flag.
// - Per detector, software picks chip reset or no reset; without reset, physical detectors also raise the tamper fast interrupt.
// - Eight detectors: frequency, voltage, temperature, light, laser, insulation, shield, glitch.
// - Reaction choice never masks or bypasses detection or filtering.
// - External reset and clock pins are glitch and high-frequency filtered.
// - Detected physical attack halts via reset or fast interrupt.
// - Without write-enable within 128 cycles, security register writes are rejected.
// - Security register reads and writes obey privilege and lock attributes.
// - Access outside the valid map raises the fast interrupt.
// - Access-control or region violations raise an unmaskable fast interrupt.
// - Eight regions, each with own data and program permissions.
// - Regions restrict user mode; privileged software configures them.
// - Region violation also sets its cause bit in the cause monitor.
// - Flash fetches are checked against execute rights; failure raises interrupt.
// - Reset returns every register, region setup included, to defaults.
// - Normal mode holds until nrst; reset returns to test mode until nvm_normal_strap is seen high or the normal command follows authentication.
// - Traceability data become read-only once normal mode is entered.
// - Test access is granted only after the tester's password verifies.
// - Test commands and functional tests are refused in normal mode.
// - RAM key dynamic, ROM key static, flash encryption under software.
`timescale 1ns/1ps
module sam_monitor
  import sam_pkg::*;
#(
  parameter logic [DW-1:0] TEST_PASSWORD = 32'h1234_5678, // Arbitrary value.
  parameter logic [DW-1:0] ROM_KEY       = 32'h0F1E_2D3C  // Arbitrary value.
)(
  // Clock and reset.
  input  wire  logic             mclk,
  input  wire  logic             nrst,
  // Detector and pin inputs.
  input  wire  logic [N_DET-1:0] det_raw,
  input  wire  logic             ext_rst_pin_n,
  input  wire  logic             ext_clk_pin,
  input  wire  logic             nvm_normal_strap,
  // Software side of the status and control.
  input  wire  logic [N_DET-1:0] det_clr,
  input  wire  logic [N_CZ-1:0]  cause_clr,
  // Security register port.
  input  wire  logic             sec_wr,
  input  wire  logic             sec_rd,
  input  wire  logic             sec_priv,
  input  wire  logic [3:0]       sec_idx,
  input  wire  logic [DW-1:0]    sec_wdata,
  output logic       [DW-1:0]    sec_rdata,
  output logic                   sec_err,
  // Memory access under check.
  input  wire  logic             acc_valid,
  input  wire  logic [AW-1:0]    acc_addr,
  input  wire  logic             acc_write,
  input  wire  logic             acc_fetch,
  input  wire  logic             acc_user,
  // Test port.
  input  wire  logic             tst_valid,
  input  wire  logic [1:0]       tst_cmd,
  input  wire  logic [DW-1:0]    tst_data,
  output logic                   tst_err,
  output logic                   func_test_start,
  output logic                   trace_we,
  output logic       [DW-1:0]    trace_data,
  output logic                   fuse_burn,
  output logic                   test_mode,
  // Reactions and status.
  output logic       [N_DET-1:0] det_flags,
  output logic       [N_CZ-1:0]  fast_irq_cause,
  output logic                   fast_irq_request,
  output logic                   chip_reset_req,
  output logic                   rst_filt_n,
  output logic                   clk_filt,
  // Encryption control.
  output logic       [DW-1:0]    ram_key,
  output logic       [DW-1:0]    rom_key,
  output logic                   flash_enc_en
);

  sam_region_if rif ();
  sam_region_check u_chk (.rif(rif.chk));

  // ----------------------------------------------------------------------
  // Synchronisers and pin filters
  // ----------------------------------------------------------------------
  logic [N_DET-1:0] det_s1_q, det_s2_q;
  logic [2:0]       pin_s1_q, pin_s2_q;
  logic [3:0]       rflt_cnt_q, rflt_cnt_d, hf_cnt_q, hf_cnt_d;
  logic             rst_filt_q, rst_filt_d, clk_filt_q, clk_filt_d;

  always_comb begin
    rst_filt_d = rst_filt_q;
    rflt_cnt_d = '0;
    clk_filt_d = clk_filt_q;
    hf_cnt_d   = '0;
    if (pin_s2_q[0] != rst_filt_q) begin
      rflt_cnt_d = rflt_cnt_q + 4'h1;
      if (rflt_cnt_q == 4'(RST_FILT_CYC - 1)) begin
        rst_filt_d = pin_s2_q[0];
        rflt_cnt_d = '0;
      end
    end
    if (pin_s2_q[1] != clk_filt_q) begin
      hf_cnt_d = hf_cnt_q + 4'h1;
      if (hf_cnt_q == 4'(HF_MIN_HALF_CYC - 1)) begin
        clk_filt_d = pin_s2_q[1];
        hf_cnt_d   = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      det_s1_q   <= '0;
      det_s2_q   <= '0;
      pin_s1_q   <= 3'h0;
      pin_s2_q   <= 3'h0;
      rflt_cnt_q <= '0;
      hf_cnt_q   <= '0;
      rst_filt_q <= 1'b0;
      clk_filt_q <= 1'b0;
    end else begin
      det_s1_q   <= det_raw;
      det_s2_q   <= det_s1_q;
      pin_s1_q   <= {nvm_normal_strap, ext_clk_pin, ext_rst_pin_n};
      pin_s2_q   <= pin_s1_q;
      rflt_cnt_q <= rflt_cnt_d;
      hf_cnt_q   <= hf_cnt_d;
      rst_filt_q <= rst_filt_d;
      clk_filt_q <= clk_filt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Security registers and write-enable window
  // ----------------------------------------------------------------------
  logic [7:0]       win_cnt_q, win_cnt_d;
  logic             wen_q, wen_d, fenc_q, fenc_d, err_q, err_d;
  logic [N_DET-1:0] react_q, react_d;
  logic [DW-1:0]    memctl_q, memctl_d, rdata_q, rdata_d;
  logic [DW-1:0]    rgn_q [N_RGN];
  logic [DW-1:0]    rgn_d [N_RGN];
  logic [N_DET-1:0] det_flag_q;
  logic [N_CZ-1:0]  cause_q;
  sam_life_e        life_q;
  logic             win_open, wr_ok;

  assign win_open = win_cnt_q < 8'(WEN_WINDOW_CYC);
  assign wr_ok    = sec_priv && (wen_q || (win_open && sec_idx == SEC_IDX_CTRL));

  always_comb begin
    win_cnt_d = win_open ? win_cnt_q + 8'h01 : win_cnt_q;
    wen_d     = wen_q;
    fenc_d    = fenc_q;
    react_d   = react_q;
    memctl_d  = memctl_q;
    rgn_d     = rgn_q;
    err_d     = 1'b0;
    rdata_d   = rdata_q;
    if (sec_wr) begin
      if (!wr_ok) begin
        err_d = 1'b1;
      end else begin
        case (sec_idx)
          SEC_IDX_REACT:  react_d  = sec_wdata[N_DET-1:0];
          SEC_IDX_MEMCTL: memctl_d = sec_wdata;
          SEC_IDX_CTRL: begin
            wen_d  = wen_q | (win_open & sec_wdata[CTRL_WEN_BIT]);
            fenc_d = sec_wdata[CTRL_FENC_BIT];
          end
          default: begin
            if (sec_idx[3]) begin
              rgn_d[sec_idx[2:0]] = sec_wdata;
            end else begin
              err_d = 1'b1;
            end
          end
        endcase
      end
    end else if (sec_rd) begin
      rdata_d = '0;
      if (!sec_priv) begin
        err_d = 1'b1;
      end else begin
        case (sec_idx)
          SEC_IDX_REACT:  rdata_d = {24'h00_0000, react_q};
          SEC_IDX_MEMCTL: rdata_d = memctl_q;
          SEC_IDX_CTRL:   rdata_d = {30'h0000_0000, fenc_q, wen_q};
          SEC_IDX_DETST:  rdata_d = {24'h00_0000, det_flag_q};
          SEC_IDX_CAUSE:  rdata_d = {28'h000_0000, cause_q};
          SEC_IDX_STATE:  rdata_d = {29'h0000_0000, life_q};
          default:        rdata_d = sec_idx[3] ? rgn_q[sec_idx[2:0]] : '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      win_cnt_q <= 8'h00;
      wen_q     <= 1'b0;
      fenc_q    <= 1'b0;
      react_q   <= REACT_RST;
      memctl_q  <= MEMCTL_RST;
      rgn_q     <= '{default: RGN_RST};
      err_q     <= 1'b0;
      rdata_q   <= '0;
    end else begin
      win_cnt_q <= win_cnt_d;
      wen_q     <= wen_d;
      fenc_q    <= fenc_d;
      react_q   <= react_d;
      memctl_q  <= memctl_d;
      rgn_q     <= rgn_d;
      err_q     <= err_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Detector flags, access checks and fast interrupt causes
  // ----------------------------------------------------------------------
  logic [N_DET-1:0] det_flag_d;
  logic [N_CZ-1:0]  cause_d, cause_new;
  logic             chip_rst_q, chip_rst_d, nmi_q, nmi_d, fl_ok;

  assign rif.cfg   = rgn_q;
  assign rif.addr  = acc_addr;
  assign rif.user  = acc_user;
  assign rif.write = acc_write;
  assign rif.fetch = acc_fetch;
  assign rif.pu_en = memctl_q[MC_PU_EN_BIT];
  assign fl_ok     = acc_user ? memctl_q[MC_FL_UX_BIT] : memctl_q[MC_FL_PX_BIT];

  always_comb begin
    cause_new             = '0;
    cause_new[CZ_INVALID] = acc_valid && (acc_addr >= MAP_TOP);
    cause_new[CZ_REGION]  = acc_valid && rif.viol;
    cause_new[CZ_FLASH_X] = acc_valid && acc_fetch && !fl_ok &&
                            in_pages(acc_addr, FLASH_BASE_PG, FLASH_LAST_PG);
    cause_new[CZ_TAMPER]  = |(det_s2_q & DET_PHYS_MASK & ~react_q);
    det_flag_d = (det_flag_q & ~det_clr) | det_s2_q;
    cause_d    = (cause_q & ~cause_clr) | cause_new;
    chip_rst_d = chip_rst_q | (|(det_s2_q & react_q));
    nmi_d      = |cause_q;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      det_flag_q <= '0;
      cause_q    <= '0;
      chip_rst_q <= 1'b0;
      nmi_q      <= 1'b0;
    end else begin
      det_flag_q <= det_flag_d;
      cause_q    <= cause_d;
      chip_rst_q <= chip_rst_d;
      nmi_q      <= nmi_d;
    end
  end

  // ----------------------------------------------------------------------
  // Test and normal life cycle, key control
  // ----------------------------------------------------------------------
  sam_life_e     life_d;
  logic          terr_q, terr_d, ftst_q, ftst_d, twe_q, twe_d, burn_q, burn_d;
  logic [DW-1:0] tdat_q, tdat_d, ramk_q, ramk_d, romk_q;

  always_comb begin
    life_d = life_q;
    terr_d = 1'b0;
    ftst_d = 1'b0;
    twe_d  = 1'b0;
    burn_d = 1'b0;
    tdat_d = tdat_q;
    ramk_d = {ramk_q[DW-2:0], ramk_q[31] ^ ramk_q[21] ^ ramk_q[1] ^ ramk_q[0]};
    case (life_q)
      ST_TEST_LOCKED: begin
        if (pin_s2_q[2]) begin
          life_d = ST_NORMAL;
        end else if (tst_valid) begin
          if (tst_cmd == TCMD_AUTH && tst_data == TEST_PASSWORD) begin
            life_d = ST_TEST_OPEN;
          end else begin
            terr_d = 1'b1;
          end
        end
      end
      ST_TEST_OPEN: begin
        if (pin_s2_q[2]) begin
          life_d = ST_NORMAL;
        end else if (tst_valid) begin
          case (tst_cmd)
            TCMD_TRACE: begin
              twe_d  = 1'b1;
              tdat_d = tst_data;
            end
            TCMD_FTEST:  ftst_d = 1'b1;
            TCMD_NORMAL: begin
              life_d = ST_NORMAL;
              burn_d = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_NORMAL: begin
        terr_d = tst_valid;
      end
      default: life_d = ST_NORMAL;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      life_q <= ST_TEST_LOCKED;
      terr_q <= 1'b0;
      ftst_q <= 1'b0;
      twe_q  <= 1'b0;
      burn_q <= 1'b0;
      tdat_q <= '0;
      ramk_q <= 32'hACE1_1357;
      romk_q <= ROM_KEY;
    end else begin
      life_q <= life_d;
      terr_q <= terr_d;
      ftst_q <= ftst_d;
      twe_q  <= twe_d;
      burn_q <= burn_d;
      tdat_q <= tdat_d;
      ramk_q <= ramk_d;
      romk_q <= ROM_KEY;
    end
  end

  assign sec_rdata        = rdata_q;
  assign sec_err          = err_q;
  assign tst_err          = terr_q;
  assign func_test_start  = ftst_q;
  assign trace_we         = twe_q;
  assign trace_data       = tdat_q;
  assign fuse_burn        = burn_q;
  assign test_mode        = (life_q != ST_NORMAL);
  assign det_flags        = det_flag_q;
  assign fast_irq_cause   = cause_q;
  assign fast_irq_request = nmi_q;
  assign chip_reset_req   = chip_rst_q;
  assign rst_filt_n       = rst_filt_q;
  assign clk_filt         = clk_filt_q;
  assign ram_key          = ramk_q;
  assign rom_key          = romk_q;
  assign flash_enc_en     = fenc_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_det_capture: assert property ((det_s2_q != '0) |=> ((det_flag_q & $past(det_s2_q)) == $past(det_s2_q)))
    else $error("detector event not captured");
  a_det_reset: assert property (|(det_s2_q & react_q) |=> chip_rst_q)
    else $error("reset reaction missing");
  a_tamper_nmi: assert property (|(det_s2_q & DET_PHYS_MASK & ~react_q) |=> cause_q[CZ_TAMPER] ##1 nmi_q)
    else $error("tamper fast interrupt missing");
  a_wen_lock: assert property ((sec_wr && !win_open && !wen_q) |=> err_q && $stable(react_q) && $stable(memctl_q))
    else $error("write accepted after window closed");
  a_rd_priv: assert property ((sec_rd && !sec_wr && !sec_priv) |=> err_q && rdata_q == '0)
    else $error("unprivileged read not refused");
  a_invalid_nmi: assert property ((acc_valid && acc_addr >= MAP_TOP) |=> cause_q[CZ_INVALID] ##1 nmi_q)
    else $error("invalid address not flagged");
  a_region_nmi: assert property ((acc_valid && rif.viol) |=> cause_q[CZ_REGION] ##1 nmi_q)
    else $error("region violation not flagged");
  a_flash_exec: assert property ((acc_valid && acc_fetch && !fl_ok && acc_addr[15:14] == 2'b01) |=> cause_q[CZ_FLASH_X])
    else $error("flash execute violation not flagged");
  a_normal_stays: assert property ((life_q == ST_NORMAL) |=> (life_q == ST_NORMAL) && !twe_q && !ftst_q)
    else $error("left normal mode or test function ran");
  a_trace_auth: assert property (twe_q |-> $past(life_q == ST_TEST_OPEN))
    else $error("trace write without authentication");

endmodule : sam_monitor

// >>> sam_monitor_tb.sv
/*
  Self-checking bench for the security access monitor.
  Assumes the processor model drives the register and access strobes.
*/
`timescale 1ns/1ps
module sam_monitor_tb;
  import sam_pkg::*;
  logic             mclk = 1'h0;
  logic             nrst = 1'h0;
  logic [N_DET-1:0] det_raw = 8'h00;
  logic [N_DET-1:0] det_clr = 8'h00;
  logic [N_CZ-1:0]  cause_clr = 4'h0;
  logic             tst_valid = 1'h0;
  logic [1:0]       tst_cmd = 2'h0;
  logic [DW-1:0]    tst_data = 32'h0000_0000;
  logic             ext_rst_pin_n = 1'h1;
  logic             ext_clk_pin = 1'h0;
  logic             sec_wr, sec_rd, sec_priv, acc_valid, acc_write, acc_fetch, acc_user;
  logic [3:0]       sec_idx;
  logic [DW-1:0]    sec_wdata, sec_rdata, trace_data, ram_key, rom_key;
  logic [AW-1:0]    acc_addr;
  logic [N_DET-1:0] det_flags;
  logic [N_CZ-1:0]  fast_irq_cause;
  logic             sec_err, tst_err, func_test_start, trace_we, fuse_burn, test_mode;
  logic             fast_irq_request, chip_reset_req, rst_filt_n, clk_filt, flash_enc_en;
  int               fails = 0;
  int               num_checks = 0;

  sam_monitor sam_monitor_i (
    .mclk, .nrst, .det_raw, .ext_rst_pin_n, .ext_clk_pin,
    .nvm_normal_strap(1'h0), .det_clr, .cause_clr, .sec_wr, .sec_rd, .sec_priv,
    .sec_idx, .sec_wdata, .sec_rdata, .sec_err, .acc_valid, .acc_addr,
    .acc_write, .acc_fetch, .acc_user, .tst_valid, .tst_cmd, .tst_data,
    .tst_err, .func_test_start, .trace_we, .trace_data, .fuse_burn,
    .test_mode, .det_flags, .fast_irq_cause, .fast_irq_request,
    .chip_reset_req, .rst_filt_n, .clk_filt, .ram_key, .rom_key, .flash_enc_en
  );
  sam_cpu_model sam_cpu_model_i (.mclk, .sec_wr, .sec_rd, .sec_priv, .sec_idx,
    .sec_wdata, .acc_valid, .acc_addr, .acc_write, .acc_fetch, .acc_user);

  initial begin
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic p, input logic [3:0] i, input logic [DW-1:0] d, input logic e);
    sam_cpu_model_i.reg_op(1'h1, p, i, d);
    #1;
    chk("sec_err", sec_err, e);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [DW-1:0] e);
    sam_cpu_model_i.reg_op(1'h0, 1'h1, i, 32'h0000_0000);
    tick();
    chk("sec_rdata", sec_rdata, e);
  endtask : rd

  task automatic acc(input logic [AW-1:0] a, input logic w, input logic f, input logic u,
                     input logic [N_CZ-1:0] e);
    sam_cpu_model_i.acc_op(a, w, f, u);
    tick();
    chk("cause", fast_irq_cause, e);
    tick();
    chk("cause held", fast_irq_cause, e);
    chk("fast_irq_request", fast_irq_request, |e);
    cause_clr <= 4'hF;
    tick();
    cause_clr <= 4'h0;
  endtask : acc

  task automatic tst(input logic [1:0] c, input logic [DW-1:0] d, input logic e);
    @(posedge mclk);
    tst_valid <= 1'h1;
    tst_cmd   <= c;
    tst_data  <= d;
    @(posedge mclk);
    tst_valid <= 1'h0;
    tst_data  <= ~d;
    #1;
    chk("tst_err", tst_err, e);
    chk("trace_we", trace_we, c == TCMD_TRACE && !e);
    chk("func_test_start", func_test_start, c == TCMD_FTEST && !e);
    chk("fuse_burn", fuse_burn, c == TCMD_NORMAL && !e);
  endtask : tst

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    #50000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    rd(4'h0, 32'h0000_0087);
    rd(4'h1, 32'h0000_0004);
    rd(4'h5, 32'h0000_0001);
    wr(1'h0, 4'h2, 32'h0000_0001, 1'h1);
    wr(1'h1, 4'h2, 32'h0000_0003, 1'h0);
    chk("flash_enc_en", flash_enc_en, 1'h1);
    wr(1'h1, 4'h0, 32'h0000_0001, 1'h0);
    wr(1'h1, 4'h3, 32'h0000_00FF, 1'h1);
    acc(16'hC000, 1'h0, 1'h0, 1'h0, 4'h1);
    acc(16'h4000, 1'h0, 1'h1, 1'h1, 4'h4);
    acc(16'h4000, 1'h0, 1'h1, 1'h0, 4'h0);
    wr(1'h1, 4'h1, 32'h0000_0005, 1'h0);
    acc(16'h1000, 1'h0, 1'h0, 1'h1, 4'h2);
    wr(1'h1, 4'h8, 32'h0003_1010, 1'h0);
    acc(16'h1000, 1'h0, 1'h0, 1'h1, 4'h0);
    acc(16'h1000, 1'h1, 1'h0, 1'h1, 4'h2);
    acc(16'h2000, 1'h1, 1'h0, 1'h0, 4'h0);
    det_raw <= 8'h10;
    repeat (5) tick();
    chk("det_flags", det_flags, 8'h10);
    chk("tamper cause", fast_irq_cause, 4'h8);
    chk("fast_irq_request", fast_irq_request, 1'h1);
    chk("chip_reset_req", chip_reset_req, 1'h0);
    det_raw <= 8'h01;
    repeat (5) tick();
    chk("chip_reset_req", chip_reset_req, 1'h1);
    chk("det_flags", det_flags, 8'h11);
    det_raw <= 8'h00;
    repeat (4) tick();
    det_clr <= 8'h11;
    tick();
    det_clr <= 8'h00;
    tick();
    chk("det_flags", det_flags, 8'h00);
    ext_rst_pin_n <= 1'h0;
    repeat (5) tick();
    ext_rst_pin_n <= 1'h1;
    tick();
    chk("rst_filt_n", rst_filt_n, 1'h1);
    ext_rst_pin_n <= 1'h0;
    repeat (15) tick();
    chk("rst_filt_n", rst_filt_n, 1'h0);
    ext_clk_pin <= 1'h1;
    repeat (8) tick();
    chk("clk_filt", clk_filt, 1'h1);
    ext_clk_pin <= 1'h0;
    repeat (2) tick();
    ext_clk_pin <= 1'h1;
    tick();
    chk("clk_filt", clk_filt, 1'h1);
    tst(TCMD_TRACE, 32'h0000_00AA, 1'h1);
    tst(TCMD_AUTH, 32'h0000_0000, 1'h1);
    tst(TCMD_AUTH, 32'h1234_5678, 1'h0);
    tst(TCMD_TRACE, 32'h0000_00AA, 1'h0);
    chk("trace_data", trace_data, 32'h0000_00AA);
    tst(TCMD_FTEST, 32'h0000_0000, 1'h0);
    tst(TCMD_NORMAL, 32'h0000_0000, 1'h0);
    chk("test_mode", test_mode, 1'h0);
    tst(TCMD_AUTH, 32'h1234_5678, 1'h1);
    tst(TCMD_TRACE, 32'h0000_00BB, 1'h1);
    tst(TCMD_FTEST, 32'h0000_0000, 1'h1);
    nrst <= 1'h0;
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    tick();
    chk("chip_reset_req", chip_reset_req, 1'h0);
    chk("test_mode", test_mode, 1'h1);
    repeat (WEN_WINDOW_CYC) @(posedge mclk);
    wr(1'h1, 4'h2, 32'h0000_0001, 1'h1);
    rd(4'h2, 32'h0000_0000);
    print_verdict();
  end
endmodule : sam_monitor_tb

// >>> sam_pkg.sv
/*
  Constants, encodings and shared helpers for the security access monitor.
  Assumes one 100 MHz system clock; the pin filter cycle counts below are derived from it.
*/
package sam_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WEN_WINDOW_CYC  = 128;
  localparam int RST_FILT_NS     = 100;
  localparam int RST_FILT_CYC    = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_MIN_HALF_NS  = 40;
  localparam int HF_MIN_HALF_CYC = (HF_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int N_DET = 8;
  localparam int N_RGN = 8;
  localparam int AW    = 16;
  localparam int DW    = 32;
  localparam int N_CZ  = 4;

  // ----------------------------------------------------------------------
  // Detector indices and physical-attack group
  // ----------------------------------------------------------------------
  localparam int DET_FREQ   = 0;
  localparam int DET_VOLT   = 1;
  localparam int DET_TEMP   = 2;
  localparam int DET_LIGHT  = 3;
  localparam int DET_LASER  = 4;
  localparam int DET_INSUL  = 5;
  localparam int DET_SHIELD = 6;
  localparam int DET_GLITCH = 7;
  localparam logic [N_DET-1:0] DET_PHYS_MASK = 8'h78;

  // ----------------------------------------------------------------------
  // Security register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] SEC_IDX_REACT  = 4'h0;
  localparam logic [3:0] SEC_IDX_MEMCTL = 4'h1;
  localparam logic [3:0] SEC_IDX_CTRL   = 4'h2;
  localparam logic [3:0] SEC_IDX_DETST  = 4'h3;
  localparam logic [3:0] SEC_IDX_CAUSE  = 4'h4;
  localparam logic [3:0] SEC_IDX_STATE  = 4'h5;
  localparam int         SEC_IDX_RGN0   = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [N_DET-1:0] REACT_RST  = 8'h87;
  localparam logic [DW-1:0]    MEMCTL_RST = 32'h0000_0004;
  localparam logic [DW-1:0]    RGN_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RGN_BASE_LSB  = 0;
  localparam int RGN_LIMIT_LSB = 8;
  localparam int RGN_EN_BIT    = 16;
  localparam int RGN_UR_BIT    = 17;
  localparam int RGN_UW_BIT    = 18;
  localparam int RGN_UX_BIT    = 19;
  localparam int MC_PU_EN_BIT  = 0;
  localparam int MC_FL_UX_BIT  = 1;
  localparam int MC_FL_PX_BIT  = 2;
  localparam int CTRL_WEN_BIT  = 0;
  localparam int CTRL_FENC_BIT = 1;
  localparam int CZ_INVALID    = 0;
  localparam int CZ_REGION     = 1;
  localparam int CZ_FLASH_X    = 2;
  localparam int CZ_TAMPER     = 3;

  // ----------------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLASH_BASE_PG = 8'h40;
  localparam logic [7:0] FLASH_LAST_PG = 8'h7F;
  localparam logic [AW-1:0] MAP_TOP    = 16'hC000;

  // ----------------------------------------------------------------------
  // Test-port commands and life-cycle states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCMD_AUTH   = 2'h0,
    TCMD_TRACE  = 2'h1,
    TCMD_FTEST  = 2'h2,
    TCMD_NORMAL = 2'h3
  } sam_tcmd_e;

  typedef enum logic [2:0] {
    ST_TEST_LOCKED = 3'b001,
    ST_TEST_OPEN   = 3'b010,
    ST_NORMAL      = 3'b100
  } sam_life_e;

  // Tells whether an address falls into an inclusive range of 256-byte pages.
  function automatic logic in_pages(input logic [AW-1:0] addr,
                                    input logic [7:0]    base,
                                    input logic [7:0]    last);
    return (addr[AW-1 -: 8] >= base) && (addr[AW-1 -: 8] <= last);
  endfunction : in_pages

endpackage : sam_pkg

// >>> sam_region_check.sv
/*
  Eight-region protection check for user-mode accesses.
  Assumes the monitor registers the verdict; privileged accesses always pass.
*/
`timescale 1ns/1ps
module sam_region_check
  import sam_pkg::*;
(
  // Region configuration and access under test.
  sam_region_if.chk rif
);

  // ----------------------------------------------------------------------
  // Permission lookup
  // ----------------------------------------------------------------------
  always_comb begin
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < N_RGN; i++) begin
      if (rif.cfg[i][RGN_EN_BIT] &&
          in_pages(rif.addr, rif.cfg[i][RGN_BASE_LSB +: 8], rif.cfg[i][RGN_LIMIT_LSB +: 8])) begin
        if (rif.fetch) begin
          ok = ok | rif.cfg[i][RGN_UX_BIT];
        end else if (rif.write) begin
          ok = ok | rif.cfg[i][RGN_UW_BIT];
        end else begin
          ok = ok | rif.cfg[i][RGN_UR_BIT];
        end
      end
    end
    rif.viol = rif.pu_en && rif.user && !ok;
  end

endmodule : sam_region_check

// >>> sam_region_if.sv
/*
  Carrier between the monitor and its region checker.
  Assumes both ends run on the monitor clock; the check is combinational.
*/
`timescale 1ns/1ps
interface sam_region_if;
  import sam_pkg::*;
  logic [DW-1:0] cfg [N_RGN];
  logic [AW-1:0] addr;
  logic          user;
  logic          write;
  logic          fetch;
  logic          pu_en;
  logic          viol;

  modport mon (output cfg, addr, user, write, fetch, pu_en, input viol);
  modport chk (input cfg, addr, user, write, fetch, pu_en, output viol);
endinterface : sam_region_if
